/* File: hdl/urg_pkg.sv */
// urg_pkg: widths, codes, reset values and timing counts shared by both
// ends of the upstream request/grant link; assumes a 40 MHz timebase clock.
package urg_pkg;
  // field widths
  localparam int TIME_W    = 32;            // timebase, ticks
  localparam int SID_W     = 14;            // service id
  localparam int LEN_W     = 12;            // interval length, mini-slots
  localparam int GR_W      = 8;             // request / grant size
  localparam int CHAN_W    = 8;             // upstream channel id
  localparam int BO_W      = 4;             // backoff exponent
  // mini-slot geometry
  localparam int SLOT_SHIFT = 2;            // 4 ticks per mini-slot
  localparam int BYTE_SHIFT = 4;            // 16 bytes per mini-slot
  localparam int MAX_GRANT  = 255;          // largest data grant
  localparam int REQ_SLOTS  = 8;            // contention region size
  localparam int EPOCH_SLOTS = 300;         // mini-slots per map
  localparam int BO_MAX     = 10;           // backoff exponent ceiling
  localparam int BO_START   = 2;            // backoff start carried in maps
  localparam int PEND_MAX   = 8;            // tdma grant steps until a zero grant is dropped
  // reserved service ids
  localparam logic [SID_W-1:0] NULL_SID  = 14'h0000;
  localparam logic [SID_W-1:0] BCAST_SID = 14'h3fff;
  // channels sharing one centre frequency
  localparam logic [CHAN_W-1:0] TDMA_CHAN = 8'h00;
  localparam logic [CHAN_W-1:0] SCD_CHAN  = 8'h01;
  // timing
  localparam int CLK_HZ    = 40_000_000;
  localparam int SYNC_MS   = 20;            // sync spacing, ms
  localparam int SYNC_CYC  = SYNC_MS * (CLK_HZ / 1000);
  localparam int UCD_S     = 2;             // ucd spacing, s
  localparam int UCD_CYC   = UCD_S * CLK_HZ;
  localparam int MAP_LEAD  = 256;           // map sent this many ticks early
  // reset values
  localparam logic [15:0]       LFSR_SEED = 16'hace1;
  localparam logic [TIME_W-1:0] EPOCH0    = 32'h0000_0400;
  // interval kinds
  typedef enum logic [1:0] {
    IE_NULL = 2'h0,
    IE_REQ  = 2'h1,
    IE_GNT  = 2'h2                          // length 0 means pending
  } urg_ie_e;
endpackage

/* File: hdl/urg_link_if.sv */
// urg_link_if: downstream maps/sync/ucd and upstream request/data bursts.
// assumes both ends run on one clock; every signal is a registered output or a constant.
`timescale 1ns/1ps
interface urg_link_if;
  import urg_pkg::*;
  // downstream, headend to modem
  logic                map_vld;             // map header pulse
  logic [CHAN_W-1:0]   map_chan;            // target upstream channel
  logic [TIME_W-1:0]   map_start;           // alloc start, ticks
  logic [TIME_W-1:0]   map_ack;             // ack time, ticks
  logic [BO_W-1:0]     map_bo;              // data backoff start
  logic                ie_vld;              // interval element pulse
  urg_ie_e             ie_kind;             // interval kind
  logic [SID_W-1:0]    ie_sid;              // owner of interval
  logic [TIME_W-1:0]   ie_start;            // interval start, ticks
  logic [LEN_W-1:0]    ie_len;              // interval length, mini-slots
  logic                map_end;             // map terminator pulse
  logic                sync_vld;            // sync pulse
  logic [TIME_W-1:0]   sync_ts;             // timestamp of this cycle
  logic                ucd_vld;             // channel descriptor pulse
  // upstream, modem to headend
  logic                req_vld;             // request burst pulse
  logic [SID_W-1:0]    req_sid;             // requesting service
  logic [GR_W-1:0]     req_len;             // mini-slots wanted
  logic                dat_vld;             // data burst pulse
  logic [SID_W-1:0]    dat_sid;             // sending service
  logic [GR_W-1:0]     dat_len;             // burst mini-slots

  modport modem (
    input  map_vld, map_chan, map_start, map_ack, map_bo, ie_vld, ie_kind,
           ie_sid, ie_start, ie_len, map_end, sync_vld, sync_ts, ucd_vld,
    output req_vld, req_sid, req_len, dat_vld, dat_sid, dat_len
  );
  modport head (
    output map_vld, map_chan, map_start, map_ack, map_bo, ie_vld, ie_kind,
           ie_sid, ie_start, ie_len, map_end, sync_vld, sync_ts, ucd_vld,
    input  req_vld, req_sid, req_len, dat_vld, dat_sid, dat_len
  );
endinterface

/* File: hdl/urg_modem.sv */
// urg_modem: modem end; contends for requests, tracks acks, sends pdus
// on grants and locks its timebase to sync timestamps.
// assumes one clock shared with the link and a headend per urg_headend.
`timescale 1ns/1ps
module urg_modem #(
  parameter logic [urg_pkg::SID_W-1:0]  SID  = 14'h0010, // own service id
  parameter logic [urg_pkg::CHAN_W-1:0] CHAN = 8'h00     // own upstream
) (
  input  wire logic                       core_clk_i, // timebase clock
  input  wire logic                       arst_n_i,   // async reset
  urg_link_if.modem                       lnk,        // cable link
  input  wire logic                       pdu_vld_i,  // pdu queued
  input  wire logic [15:0]                pdu_len_i,  // pdu bytes
  input  wire logic [urg_pkg::TIME_W-1:0] rng_ofs_i,  // ranging offset
  output logic                            pdu_rdy_o,  // may queue a pdu
  output logic                            tx_done_o,  // pdu sent pulse
  output logic                            lost_o,     // request lost pulse
  output logic                            pend_o,     // zero grant held
  output logic                            synced_o,   // timebase locked
  output logic [urg_pkg::TIME_W-1:0]      time_o      // local time
);
  import urg_pkg::*;

  typedef enum logic [4:0] {
    M_IDLE = 5'h01,
    M_CONT = 5'h02,
    M_REQ  = 5'h04,
    M_ACK  = 5'h08,
    M_DATA = 5'h10
  } urg_mst_e;

  urg_mst_e          st_q;
  logic [TIME_W-1:0] time_q;
  logic              synced_q;
  logic              mine_q;
  logic [TIME_W-1:0] ack_q;
  logic [BO_W-1:0]   bo_start_q;
  logic              ack_seen_q;
  logic [15:0]       lfsr_q;
  logic [BO_W-1:0]   bo_q;
  logic [15:0]       defer_q;
  logic [TIME_W-1:0] launch_q;
  logic [TIME_W-1:0] arr_q;
  logic [GR_W-1:0]   need_q;
  logic [GR_W-1:0]   glen_q;
  logic              pend_q;
  logic              rdy_q;
  logic              done_q;
  logic              lost_q;
  logic              req_q;
  logic              dat_q;

  // mini-slots for a pdu, rounded up and capped at the grant ceiling
  function automatic logic [GR_W-1:0] slots_for(input logic [15:0] len);
    logic [16:0] s;
    s = (17'(len) + 17'h0000f) >> BYTE_SHIFT;
    slots_for = (s > 17'(MAX_GRANT)) ? GR_W'(MAX_GRANT) : s[GR_W-1:0];
  endfunction

  // backoff window mask, 2^b - 1
  function automatic logic [15:0] bo_mask(input logic [BO_W-1:0] b);
    bo_mask = 16'((32'h1 << b) - 32'h1);
  endfunction

  logic [BO_W-1:0]   bo_up;
  logic [TIME_W-1:0] due_dt;
  logic [TIME_W-1:0] cov_dt;
  logic              my_ie;
  logic              ie_req;
  logic              ie_gnt;
  logic              due;
  logic              late;
  logic              covered;
  logic              map_done;

  assign my_ie    = lnk.ie_vld && mine_q;
  assign ie_req   = my_ie && (lnk.ie_kind == IE_REQ);
  assign ie_gnt   = my_ie && (lnk.ie_kind == IE_GNT) && (lnk.ie_sid == SID);
  assign due_dt   = time_q - launch_q;
  assign cov_dt   = ack_q - arr_q;
  // launch only while locked, so a stale timebase never fires a burst
  assign due      = synced_q && (due_dt == '0);
  assign late     = synced_q && !due_dt[TIME_W-1] && (due_dt != '0);
  assign covered  = !cov_dt[TIME_W-1];
  assign map_done = lnk.map_end && mine_q;
  assign bo_up    = (bo_q < BO_W'(BO_MAX)) ? bo_q + 4'h1 : BO_W'(BO_MAX);

  // local timebase; a sync loads its stamp plus the cycle it took to land
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      time_q   <= '0;
      synced_q <= 1'b0;
    end else if (lnk.sync_vld) begin
      time_q   <= time_q + (lnk.sync_ts - time_q) + 32'h1;
      synced_q <= 1'b1;
    end else begin
      time_q   <= time_q + 32'h1;
    end
  end

  // map header capture for our channel only
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mine_q     <= 1'b0;
      ack_q      <= '0;
      bo_start_q <= '0;
      ack_seen_q <= 1'b0;
    end else begin
      if (lnk.map_vld && (lnk.map_chan == CHAN)) begin
        mine_q     <= 1'b1;
        ack_q      <= lnk.map_ack;
        bo_start_q <= lnk.map_bo;
      end else if (lnk.map_end) begin
        mine_q <= 1'b0;
      end
      if (lnk.map_vld) begin
        ack_seen_q <= 1'b0;
      end else if (ie_gnt) begin
        ack_seen_q <= 1'b1;
      end
    end
  end

  // random source for slot choice
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lfsr_q <= LFSR_SEED;
    end else begin
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    end
  end

  // request / grant sequence; one request in flight at a time
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q     <= M_IDLE;
      bo_q     <= '0;
      defer_q  <= '0;
      launch_q <= '0;
      arr_q    <= '0;
      need_q   <= '0;
      glen_q   <= '0;
      pend_q   <= 1'b0;
      rdy_q    <= 1'b0;
      done_q   <= 1'b0;
      lost_q   <= 1'b0;
      req_q    <= 1'b0;
      dat_q    <= 1'b0;
    end else begin
      done_q <= 1'b0;
      lost_q <= 1'b0;
      req_q  <= 1'b0;
      dat_q  <= 1'b0;
      case (st_q)
        M_IDLE: begin
          rdy_q <= synced_q;
          if (pdu_vld_i && rdy_q) begin
            rdy_q   <= 1'b0;
            need_q  <= slots_for(pdu_len_i);
            bo_q    <= bo_start_q;
            defer_q <= lfsr_q & bo_mask(bo_start_q);
            st_q    <= M_CONT;
          end
        end
        M_CONT: begin
          // skip whole request regions until the drawn slot falls inside one
          if (ie_req) begin
            if (defer_q < 16'(lnk.ie_len)) begin
              arr_q    <= lnk.ie_start + (TIME_W'(defer_q) << SLOT_SHIFT);
              launch_q <= lnk.ie_start + (TIME_W'(defer_q) << SLOT_SHIFT)
                          - rng_ofs_i;
              st_q     <= M_REQ;
            end else begin
              defer_q <= defer_q - 16'(lnk.ie_len);
            end
          end
        end
        M_REQ: begin
          if (due) begin
            req_q <= 1'b1;
            st_q  <= M_ACK;
          end else if (late) begin
            // opportunity already gone; redraw as for a loss
            bo_q    <= bo_up;
            defer_q <= lfsr_q & bo_mask(bo_up);
            st_q    <= M_CONT;
          end
        end
        M_ACK: begin
          if (ie_gnt && (lnk.ie_len != '0)) begin
            glen_q   <= lnk.ie_len[GR_W-1:0];
            launch_q <= lnk.ie_start - rng_ofs_i;
            pend_q   <= 1'b0;
            st_q     <= M_DATA;
          end else if (ie_gnt) begin
            pend_q <= 1'b1;
          end else if (map_done && covered && !ack_seen_q) begin
            lost_q  <= 1'b1;
            pend_q  <= 1'b0;
            bo_q    <= bo_up;
            defer_q <= lfsr_q & bo_mask(bo_up);
            st_q    <= M_CONT;
          end
        end
        M_DATA: begin
          if (due) begin
            dat_q  <= 1'b1;
            done_q <= 1'b1;
            st_q   <= M_IDLE;
          end else if (late) begin
            bo_q    <= bo_up;
            defer_q <= lfsr_q & bo_mask(bo_up);
            st_q    <= M_CONT;
          end
        end
        default: begin
          st_q <= M_IDLE;
        end
      endcase
    end
  end

  // upstream bursts and user outputs, all flops but the constant req_sid and dat_sid
  assign lnk.req_vld = req_q;
  assign lnk.req_sid = SID;
  assign lnk.req_len = need_q;
  assign lnk.dat_vld = dat_q;
  assign lnk.dat_sid = SID;
  assign lnk.dat_len = glen_q;
  assign pdu_rdy_o   = rdy_q;
  assign tx_done_o   = done_q;
  assign lost_o      = lost_q;
  assign pend_o      = pend_q;
  assign synced_o    = synced_q;
  assign time_o      = time_q;
endmodule // urg_modem

/* File: hdl/urg_headend.sv */
// urg_headend: headend end; emits sync and ucd, builds one map per
// logical upstream per epoch, mutes the idle one, answers requests.
// assumes one clock shared with the link; the modem drives upstream.
`timescale 1ns/1ps
module urg_headend #(
  parameter int SYNC_CYC = urg_pkg::SYNC_CYC, // sync spacing, cycles
  parameter int UCD_CYC  = urg_pkg::UCD_CYC   // ucd spacing, cycles
) (
  input  wire logic                       core_clk_i,  // timebase clock
  input  wire logic                       arst_n_i,    // async reset
  urg_link_if.head                        lnk,         // cable link
  input  wire logic [urg_pkg::GR_W-1:0]   budget_i,    // grantable slots
  output logic                            req_seen_o,  // request taken
  output logic                            burst_o,     // data burst pulse
  output logic [urg_pkg::SID_W-1:0]       burst_sid_o, // burst owner
  output logic [urg_pkg::GR_W-1:0]        burst_len_o, // burst size
  output logic [urg_pkg::TIME_W-1:0]      time_o       // headend time
);
  import urg_pkg::*;

  typedef enum logic [9:0] {
    H_IDLE = 10'h001, H_HDR = 10'h002, H_GRD = 10'h004,
    H_REQ  = 10'h008, H_GNT = 10'h010, H_END = 10'h020,
    H_MHDR = 10'h040, H_MNUL = 10'h080, H_MEND = 10'h100,
    H_MZG  = 10'h200
  } urg_hst_e;

  urg_hst_e          st_q;
  logic [TIME_W-1:0] time_q, next_q, ofs_q;
  logic [31:0]       sync_cnt_q, ucd_cnt_q;
  logic              scd_q, prev_scd_q;
  logic              pend_q, clr;
  logic [SID_W-1:0]  pend_sid_q;
  logic [GR_W-1:0]   pend_len_q;
  logic [3:0]        pend_cnt_q;
  logic              seen_q, bst_q;
  logic [SID_W-1:0]  bsid_q;
  logic [GR_W-1:0]   blen_q;
  logic              sync_q, ucd_q, mv_q, iv_q, me_q;
  logic [TIME_W-1:0] ts_q, mstart_q, mack_q, istart_q;
  logic [CHAN_W-1:0] mchan_q;
  urg_ie_e           ikind_q;
  logic [SID_W-1:0]  isid_q;
  logic [LEN_W-1:0]  ilen_q;

  // pending entry leaves when granted or given up in the grant step
  // only tdma maps answer requests; modems never listen to the code-division map
  assign clr = (st_q == H_GNT) && !scd_q && pend_q
               && ((pend_len_q <= budget_i) || (pend_cnt_q == 4'(PEND_MAX - 1)));

  // timebase, sync and ucd cadence; stamp names the cycle it is on the wire
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      time_q <= '0; sync_cnt_q <= '0; ucd_cnt_q <= '0;
      sync_q <= 1'b0; ucd_q <= 1'b0; ts_q <= '0;
    end else begin
      time_q     <= time_q + 32'h1;
      sync_q     <= (sync_cnt_q == 32'(SYNC_CYC - 1));
      ts_q       <= time_q + 32'h1;
      sync_cnt_q <= (sync_cnt_q == 32'(SYNC_CYC - 1)) ? '0 : sync_cnt_q + 32'h1;
      ucd_q      <= (ucd_cnt_q == 32'(UCD_CYC - 1));
      ucd_cnt_q  <= (ucd_cnt_q == 32'(UCD_CYC - 1)) ? '0 : ucd_cnt_q + 32'h1;
    end
  end

  // pending request table of one; a request meeting a clear is kept
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pend_q <= 1'b0; pend_sid_q <= '0; pend_len_q <= '0; pend_cnt_q <= '0;
      seen_q <= 1'b0;
    end else begin
      seen_q <= 1'b0;
      if (lnk.req_vld && (!pend_q || clr)) begin
        pend_q <= 1'b1; pend_sid_q <= lnk.req_sid;
        pend_len_q <= lnk.req_len; pend_cnt_q <= '0; seen_q <= 1'b1;
      end else if (clr) begin
        pend_q <= 1'b0;
      end else if ((st_q == H_GNT) && !scd_q && pend_q) begin
        pend_cnt_q <= pend_cnt_q + 4'h1;
      end
    end
  end

  // data bursts seen upstream
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bst_q <= 1'b0; bsid_q <= '0; blen_q <= '0;
    end else begin
      bst_q <= lnk.dat_vld;
      if (lnk.dat_vld) begin
        bsid_q <= lnk.dat_sid; blen_q <= lnk.dat_len;
      end
    end
  end

  // map builder: active channel map, then a muting map for the other one
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= H_IDLE; next_q <= EPOCH0; ofs_q <= '0;
      scd_q <= 1'b0; prev_scd_q <= 1'b0;
      mv_q <= 1'b0; iv_q <= 1'b0; me_q <= 1'b0; mchan_q <= '0;
      mstart_q <= '0; mack_q <= '0; istart_q <= '0;
      ikind_q <= IE_NULL; isid_q <= '0; ilen_q <= '0;
    end else begin
      mv_q <= 1'b0; iv_q <= 1'b0; me_q <= 1'b0;
      case (st_q)
        H_IDLE: if (time_q == next_q - TIME_W'(MAP_LEAD)) st_q <= H_HDR;
        H_HDR: begin
          mv_q <= 1'b1;
          mchan_q <= scd_q ? SCD_CHAN : TDMA_CHAN;
          mstart_q <= next_q;
          mack_q <= time_q;
          ofs_q <= next_q;
          st_q <= (!scd_q && prev_scd_q) ? H_GRD : H_REQ;
        end
        H_GRD: begin
          iv_q <= 1'b1; ikind_q <= IE_NULL; isid_q <= NULL_SID;
          istart_q <= ofs_q; ilen_q <= LEN_W'(1);
          ofs_q <= ofs_q + (TIME_W'(1) << SLOT_SHIFT);
          st_q <= H_REQ;
        end
        H_REQ: begin
          iv_q <= 1'b1; ikind_q <= IE_REQ; isid_q <= BCAST_SID;
          istart_q <= ofs_q; ilen_q <= LEN_W'(REQ_SLOTS);
          ofs_q <= ofs_q + (TIME_W'(REQ_SLOTS) << SLOT_SHIFT);
          st_q <= H_GNT;
        end
        H_GNT: begin
          // grant fits budget; else zero grant until the repeat limit
          if (!scd_q && pend_q && (pend_len_q <= budget_i)) begin
            iv_q <= 1'b1; ikind_q <= IE_GNT; isid_q <= pend_sid_q;
            istart_q <= ofs_q; ilen_q <= LEN_W'(pend_len_q);
          end else if (!scd_q && pend_q && !clr) begin
            iv_q <= 1'b1; ikind_q <= IE_GNT; isid_q <= pend_sid_q;
            istart_q <= ofs_q; ilen_q <= '0;
          end
          st_q <= H_END;
        end
        H_END: begin
          me_q <= 1'b1;
          st_q <= H_MHDR;
        end
        H_MHDR: begin
          mv_q <= 1'b1; mack_q <= time_q; mstart_q <= next_q;
          mchan_q <= scd_q ? TDMA_CHAN : SCD_CHAN;
          st_q <= H_MNUL;
        end
        H_MNUL: begin
          // whole epoch to the null id so the shared band stays clear
          iv_q <= 1'b1; ikind_q <= IE_NULL; isid_q <= NULL_SID;
          istart_q <= next_q; ilen_q <= LEN_W'(EPOCH_SLOTS);
          st_q <= (scd_q && pend_q) ? H_MZG : H_MEND;
        end
        H_MZG: begin
          // a muted tdma map still repeats the zero grant, else the modem sees a loss
          iv_q <= 1'b1; ikind_q <= IE_GNT; isid_q <= pend_sid_q;
          istart_q <= next_q; ilen_q <= '0;
          st_q <= H_MEND;
        end
        H_MEND: begin
          me_q <= 1'b1;
          next_q <= next_q + (TIME_W'(EPOCH_SLOTS) << SLOT_SHIFT);
          prev_scd_q <= scd_q;
          scd_q <= !scd_q;
          st_q <= H_IDLE;
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  // link and user outputs, all flops but the constant map_bo
  assign lnk.map_vld = mv_q;    assign lnk.map_chan = mchan_q;
  assign lnk.map_start = mstart_q; assign lnk.map_ack = mack_q;
  assign lnk.map_bo = BO_W'(BO_START);
  assign lnk.ie_vld = iv_q;     assign lnk.ie_kind = ikind_q;
  assign lnk.ie_sid = isid_q;   assign lnk.ie_start = istart_q;
  assign lnk.ie_len = ilen_q;   assign lnk.map_end = me_q;
  assign lnk.sync_vld = sync_q; assign lnk.sync_ts = ts_q;
  assign lnk.ucd_vld = ucd_q;
  assign req_seen_o = seen_q;   assign burst_o = bst_q;
  assign burst_sid_o = bsid_q;  assign burst_len_o = blen_q;
  assign time_o = time_q;
endmodule // urg_headend

/* File: bench/urg_asserts.sv */
// urg_asserts: timing and framing checks on the link between both ends.
// assumes the bench wires the shared link signals on one clock.
`timescale 1ns/1ps
module urg_asserts (
  input wire logic                       core_clk_i, // timebase clock
  input wire logic                       arst_n_i,   // async reset
  input wire logic                       map_vld,    // map header
  input wire logic [urg_pkg::CHAN_W-1:0] map_chan,   // map channel
  input wire logic                       ie_vld,     // element pulse
  input wire urg_pkg::urg_ie_e           ie_kind,    // element kind
  input wire logic [urg_pkg::SID_W-1:0]  ie_sid,     // element owner
  input wire logic [urg_pkg::LEN_W-1:0]  ie_len,     // element length
  input wire logic                       map_end,    // map terminator
  input wire logic                       sync_vld,   // sync pulse
  input wire logic                       ucd_vld,    // descriptor pulse
  input wire logic                       req_vld,    // request pulse
  input wire logic [urg_pkg::GR_W-1:0]   req_len     // request size
);
  import urg_pkg::*;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  // framing: header, elements one per cycle, terminator
  map_frame_a: assert property (map_vld |-> ##[2:4] map_end)
    else $error("map not terminated in time");
  head_elem_a: assert property (map_vld |=> ie_vld)
    else $error("map header not followed by element");
  // every request region is followed by the muting map of the other channel
  mute_null_a: assert property (ie_vld && ie_kind == IE_REQ |-> ##3 map_vld ##1
    ie_vld && ie_kind == IE_NULL && ie_sid == NULL_SID && ie_len == 12'(EPOCH_SLOTS))
    else $error("idle channel not muted");
  chan_id_a: assert property (map_vld |-> map_chan == TDMA_CHAN || map_chan == SCD_CHAN)
    else $error("map for unknown channel");
  grant_max_a: assert property (ie_vld && ie_kind == IE_GNT |-> ie_len <= 12'(MAX_GRANT))
    else $error("grant too large");
  req_size_a: assert property (req_vld |-> req_len != 8'h00)
    else $error("empty request");
  // a second request can only follow a map verdict, never this close
  req_gap_a: assert property (req_vld |=> !req_vld [*8])
    else $error("requests too close");
  sync_gap_a: assert property ($rose(sync_vld) |=> !sync_vld [*8])
    else $error("sync too frequent");
  ucd_gap_a: assert property ($rose(ucd_vld) |=> !ucd_vld [*8])
    else $error("ucd too frequent");
endmodule // urg_asserts

/* File: bench/upstream_request_grant_timing_tb.sv */
// upstream_request_grant_timing_tb: modem and headend joined by the link.
// assumes shortened sync/ucd spacing; ranging offset 0 for exact timing.
`timescale 1ns/1ps
module upstream_request_grant_timing_tb;
  import urg_pkg::*;
  logic core_clk_i = 0, arst_n_i = 0, pdu_vld = 0;
  logic [15:0] pdu_len = 16'h0001;
  logic [GR_W-1:0] budget = 8'hff, req_q, dat_q, bst_q;
  logic [TIME_W-1:0] mt, ht;
  logic rdy, done, pend, sync, lost, seen, bst;
  logic [SID_W-1:0] bsid;
  int n_errors = 0, compares = 0, bad_req = 0, seed = 32'h0f4a, i;
  int n_lost = 0, n_seen = 0, n_bst = 0;
  logic [15:0] lens [4] = '{16'h0010, 16'h0011, 16'h0ff0, 16'hffff};
  urg_link_if lnk();
  urg_modem u_urg_modem (.core_clk_i, .arst_n_i, .lnk(lnk), .pdu_vld_i(pdu_vld),
    .pdu_len_i(pdu_len), .rng_ofs_i(32'h0), .pdu_rdy_o(rdy), .tx_done_o(done),
    .lost_o(lost), .pend_o(pend), .synced_o(sync), .time_o(mt));
  urg_headend #(.SYNC_CYC(200), .UCD_CYC(5000)) u_urg_headend (.core_clk_i, .arst_n_i,
    .lnk(lnk), .budget_i(budget), .req_seen_o(seen), .burst_o(bst), .burst_sid_o(bsid),
    .burst_len_o(bst_q), .time_o(ht));
  urg_asserts u_urg_asserts (.core_clk_i, .arst_n_i, .map_vld(lnk.map_vld),
    .map_chan(lnk.map_chan), .ie_vld(lnk.ie_vld), .ie_kind(lnk.ie_kind),
    .ie_sid(lnk.ie_sid), .ie_len(lnk.ie_len), .map_end(lnk.map_end),
    .sync_vld(lnk.sync_vld), .ucd_vld(lnk.ucd_vld), .req_vld(lnk.req_vld),
    .req_len(lnk.req_len));
  always #12.5 core_clk_i = ~core_clk_i;
  // capture burst sizes; a request while a zero grant stands is illegal
  always @(posedge core_clk_i) begin
    if (lnk.req_vld) req_q <= lnk.req_len;
    if (lnk.dat_vld) dat_q <= lnk.dat_len;
    if (lnk.req_vld && pend) bad_req++;
    if (lost === 1'b1) n_lost++;
    if (seen === 1'b1) n_seen++;
    if (bst === 1'b1) n_bst++;
  end
  function automatic logic [GR_W-1:0] need(input logic [15:0] l);
    int n;
    n = (int'(l) + 15) / 16;
    return (n > MAX_GRANT) ? 8'hff : 8'(n);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // bounded wait: 0 synced, 1 pdu sent, 2 zero grant held, 3 ready
  task automatic wt(input int k);
    int c;
    for (c = 0; c < 40000; c++) begin
      @(negedge core_clk_i);
      if ((k == 0 && sync === 1'b1) || (k == 1 && done === 1'b1) ||
          (k == 2 && pend === 1'b1) || (k == 3 && rdy === 1'b1)) return;
    end
    n_errors++;
    $display("[ERR] %0t wait %0d timed out", $time, k);
    test_done();
  endtask
  // offer one pdu and follow it to the data burst
  task automatic send(input logic [15:0] l);
    wt(3);
    pdu_vld = 1;
    pdu_len = l;
    @(negedge core_clk_i);
    pdu_vld = 0;
    wt(1);
    repeat (2) @(negedge core_clk_i);
    chk(32'(req_q), 32'(need(l)));
    chk(32'(dat_q), 32'(need(l)));
    chk(32'(bst_q), 32'(need(l)));
    chk(32'(bsid), 32'h0000_0010);
    $display("pdu of %0d bytes done", l);
  endtask
  initial begin
    repeat (8) @(negedge core_clk_i);
    arst_n_i = 1;
    wt(0);
    repeat (3) @(negedge core_clk_i);
    chk(mt, ht);
    $display("timebase lock test done");
    for (i = 0; i < 4; i++) send(lens[i]);
    for (i = 0; i < 4; i++) send(16'($random(seed)) | 16'h0001);
    // no budget: zero grant must hold the queue without new requests
    budget = 8'h00;
    pdu_len = 16'h0100;
    wt(3);
    pdu_vld = 1;
    @(negedge core_clk_i);
    pdu_vld = 0;
    wt(2);
    repeat (3000) @(negedge core_clk_i);
    chk(32'(bad_req), 32'h0);
    budget = 8'hff;
    wt(1);
    $display("pending grant test done");
    repeat (2) @(negedge core_clk_i);
    chk(32'(n_seen), 32'h9);
    chk(32'(n_bst), 32'h9);
    chk(32'(n_lost), 32'h0);
    test_done();
  end
endmodule // upstream_request_grant_timing_tb
